//--- common/rcaw_pkg.sv
// constants, field positions and carrier types of the supervisory block
// assumes a 125 MHz system clock and a 32,768 Hz crystal input
package rcaw_pkg;

    // ==========================================================
    // register addresses
    localparam logic [12:0] ADDR_FLAGS = 13'h1FF0;
    localparam logic [12:0] ADDR_ALM_SEC = 13'h1FF2;
    localparam logic [12:0] ADDR_ALM_MIN = 13'h1FF3;
    localparam logic [12:0] ADDR_ALM_HOUR = 13'h1FF4;
    localparam logic [12:0] ADDR_ALM_DATE = 13'h1FF5;
    localparam logic [12:0] ADDR_IRQ_EN = 13'h1FF6;
    localparam logic [12:0] ADDR_WDOG = 13'h1FF7;
    localparam logic [12:0] ADDR_CTRL = 13'h1FF8;
    localparam logic [12:0] ADDR_SEC = 13'h1FF9;
    localparam logic [12:0] ADDR_DAY = 13'h1FFC;

    // ==========================================================
    // field positions and reset values
    localparam int BIT_MSB = 7;
    localparam int FLAG_WDF = 7;
    localparam int FLAG_AF = 6;
    localparam int IRQ_AFE = 7;
    localparam int IRQ_ABE = 5;
    localparam int CTRL_WR = 7;
    localparam int CTRL_RD = 6;
    localparam int CTRL_SIGN = 5;
    localparam int DAY_FT = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [6:0] DATE_OFF = 7'h00;

    // ==========================================================
    // alarm repeat codes, fourth bit first
    localparam logic [3:0] RPT_SEC = 4'hF;
    localparam logic [3:0] RPT_MIN = 4'hE;
    localparam logic [3:0] RPT_HOUR = 4'hC;
    localparam logic [3:0] RPT_DAY = 4'h8;
    localparam logic [3:0] RPT_MONTH = 4'h0;

    // ==========================================================
    // timing
    localparam logic [15:0] SEC_OSC = 16'h8000;
    localparam logic [15:0] CAL_FAST = 16'h0100;
    localparam logic [15:0] CAL_SLOW = 16'h0080;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [10:0] WD_TICK_LAST = 11'h7FF;
    localparam logic [4:0] FT_HALF_LAST = 5'h1F;
    localparam int CLK_MHZ = 125;
    localparam int T_REC_US = 200000;
    localparam int REC_CYCLES_DEF = T_REC_US * CLK_MHZ;
    localparam int REC_W = 25;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] data;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } rcaw_bus_type;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
    } rcaw_time_type;

    localparam rcaw_bus_type BUS_IDLE = '{13'h0000, 8'h00, 1'b1, 1'b1, 1'b1};

    typedef enum logic [2:0] {
        PWR_UP = 3'b001,
        PWR_DOWN = 3'b010,
        PWR_REC = 3'b100
    } rcaw_pwr_type;

endpackage

//--- rtl/rcaw_core.sv
// calibrated divider, alarm, watchdog, frequency test and reset supervisor
// assumes bus pins, crystal and power-fail are asynchronous pins and the
// time counters sit outside on the same clock, stepping on sec_tick_o
`timescale 1ns/10ps
`default_nettype none

// Operation
// - calibration adds or blanks counts at the divide-by-256 stage
// - five-bit calibration magnitude 0 to 31 in control bits 4..0
// - control bit 5 one adds counts, zero removes counts
// - 64-minute cycle, one second per minute shortened 256 or lengthened 128
// - magnitude N corrects only the first 2N minutes of the cycle
// - 512 Hz test output under halt, test, enable and steering conditions
// - power-down clears the frequency-test enable
// - four alarm registers, each MSB one repeat bit
// - repeat code picks second, minute, hour, day, month; others every second
// - match sets alarm flag; with irq enable drives interrupt low
// - flags read clears alarm flag and interrupt; next read shows it
// - in back-up, interrupt needs both back-up and irq enables; a watchdog interrupt held from before power-down stays on without them
// - power-up clears back-up and irq enables; flag still set
// - watchdog multiplier bits 6..2, resolution bits 1..0
// - time-out is multiplier times resolution, within one unit
// - expiry sets watchdog flag; flags read clears it
// - steering zero drives interrupt, one pulses reset for recovery time
// - steered expiry clears watchdog, test and both alarm enables
// - watchdog rewrite restarts period; all zeros disables it
// - power-down clears watchdog; interrupts beat frequency test
// - reset low from power fail until recovery time after return
// - halt bit is seconds MSB; stops and restarts the divider
module rcaw_core import rcaw_pkg::*; #(
    parameter int REC_CYCLES = REC_CYCLES_DEF
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // host memory bus
    input wire rcaw_bus_type bus_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // crystal, supply and time core
    input wire logic osc_32k_i,
    input wire logic power_fail_i,
    input wire rcaw_time_type cur_time_i,
    output logic sec_tick_o,
    // open-drain pins
    output logic interrupt_test_out_n_o,
    output logic interrupt_test_oe_o,
    output logic reset_out_n_o,
    output logic reset_out_oe_o
);

    // ==========================================================
    // functions
    function automatic logic bcd_eq(input logic [7:0] a, input logic [7:0] t);
        bcd_eq = (a[6:0] == t[6:0]);
    endfunction

    function automatic logic [15:0] sec_last(input logic [7:0] c, input logic fix);
        if (!fix) begin
            sec_last = SEC_OSC - 16'h0001;
        end else if (c[CTRL_SIGN]) begin
            sec_last = SEC_OSC - CAL_FAST - 16'h0001;
        end else begin
            sec_last = SEC_OSC + CAL_SLOW - 16'h0001;
        end
    endfunction

    function automatic logic [10:0] wd_units(input logic [7:0] w);
        case (w[1:0])
            2'h0: wd_units = {6'h00, w[6:2]};
            2'h1: wd_units = {4'h0, w[6:2], 2'h0};
            2'h2: wd_units = {2'h0, w[6:2], 4'h0};
            default: wd_units = {w[6:2], 6'h00};
        endcase
    endfunction

    // ==========================================================
    // pin synchronisers
    rcaw_bus_type bus_s1_q, bus_s2_q, bus_d_q;
    logic osc_s1_q, osc_s2_q, osc_d_q;
    logic pf_s1_q, pf_s2_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_s1_q <= BUS_IDLE;
            bus_s2_q <= BUS_IDLE;
            bus_d_q <= BUS_IDLE;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_d_q <= 1'b0;
            pf_s1_q <= 1'b0;
            pf_s2_q <= 1'b0;
        end else begin
            bus_s1_q <= bus_i;
            bus_s2_q <= bus_s1_q;
            bus_d_q <= bus_s2_q;
            osc_s1_q <= osc_32k_i;
            osc_s2_q <= osc_s1_q;
            osc_d_q <= osc_s2_q;
            pf_s1_q <= power_fail_i;
            pf_s2_q <= pf_s1_q;
        end
    end

    // ==========================================================
    // registers and state
    rcaw_pwr_type pwr_q, pwr_d;
    logic [7:0] wdog_q, ctrl_q, irq_en_q;
    logic [7:0] alm_q [0:3];
    logic st_q, ft_q, af_q, wdf_q, wd_irq_q, rd_flags_q;
    logic [15:0] sec_div_q;
    logic [5:0] sec_idx_q, cal_min_q;
    logic [10:0] free_q, wd_cnt_q;
    logic [REC_W-1:0] rec_q;
    logic tick_q, tick_d1_q, tick_d2_q, ft_lvl_q, irq_oe_q;
    logic [7:0] data_q;

    // ==========================================================
    // power sequencing
    wire go_down = pf_s2_q && (pwr_q != PWR_DOWN);
    wire go_up = !pf_s2_q && (pwr_q == PWR_DOWN);
    wire battery = (pwr_q == PWR_DOWN);
    wire host_ok = (pwr_q == PWR_UP);

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_UP: begin
                if (pf_s2_q) pwr_d = PWR_DOWN;
            end
            PWR_DOWN: begin
                if (!pf_s2_q) pwr_d = PWR_REC;
            end
            PWR_REC: begin
                if (pf_s2_q) pwr_d = PWR_DOWN;
                else if (rec_q == '0) pwr_d = PWR_UP;
            end
            default: pwr_d = PWR_DOWN;
        endcase
    end

    // ==========================================================
    // bus decode
    wire rd_act = !bus_s2_q.ce_n && !bus_s2_q.oe_n && bus_s2_q.we_n && host_ok;
    wire wr_end = bus_s2_q.we_n && !bus_d_q.we_n && !bus_d_q.ce_n && host_ok;
    wire [12:0] wa = bus_d_q.addr;
    wire [7:0] wd = bus_d_q.data;
    wire [12:0] ra = bus_s2_q.addr;
    wire wr_wdog = wr_end && (wa == ADDR_WDOG);
    wire wr_ctrl = wr_end && (wa == ADDR_CTRL);
    wire wr_irq = wr_end && (wa == ADDR_IRQ_EN);
    wire wr_sec = wr_end && (wa == ADDR_SEC);
    wire wr_day = wr_end && (wa == ADDR_DAY);
    wire wr_alm = wr_end && (wa >= ADDR_ALM_SEC) && (wa <= ADDR_ALM_DATE);
    wire [1:0] alm_wi = wa[1:0] - 2'h2;
    wire rd_flags = rd_act && (ra == ADDR_FLAGS);
    wire clr_flags = rd_flags_q && !rd_flags;
    wire [1:0] alm_ri = ra[1:0] - 2'h2;
    wire rd_alm = (ra >= ADDR_ALM_SEC) && (ra <= ADDR_ALM_DATE);

    wire [7:0] rd_data =
        (ra == ADDR_FLAGS) ? {wdf_q, af_q, 6'h00} :
        rd_alm ? alm_q[alm_ri] :
        (ra == ADDR_IRQ_EN) ? irq_en_q :
        (ra == ADDR_WDOG) ? wdog_q :
        (ra == ADDR_CTRL) ? ctrl_q :
        (ra == ADDR_SEC) ? {st_q, cur_time_i.sec[6:0]} :
        (ra == ADDR_DAY) ? {1'b0, ft_q, 6'h00} : 8'h00;
    wire rd_hit = (ra == ADDR_FLAGS) || rd_alm || (ra >= ADDR_IRQ_EN && ra <= ADDR_SEC)
        || (ra == ADDR_DAY);

    // ==========================================================
    // calibrated seconds divider
    wire osc_rise = osc_s2_q && !osc_d_q && !st_q;
    wire cal_fix = (sec_idx_q == 6'h00) && (cal_min_q < {ctrl_q[4:0], 1'b0});
    wire [15:0] div_last = sec_last(ctrl_q, cal_fix);
    wire sec_end = osc_rise && (sec_div_q >= div_last);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_div_q <= '0;
            sec_idx_q <= '0;
            cal_min_q <= '0;
        end else if (sec_end) begin
            sec_div_q <= '0;
            sec_idx_q <= (sec_idx_q == SEC_LAST) ? 6'h00 : sec_idx_q + 6'h01;
            cal_min_q <= (sec_idx_q == SEC_LAST) ? cal_min_q + 6'h01 : cal_min_q;
        end else if (osc_rise) begin
            sec_div_q <= sec_div_q + 16'h0001;
        end
    end

    // ==========================================================
    // free prescaler for test output and watchdog
    wire ft_edge = osc_rise && (free_q[4:0] == FT_HALF_LAST);
    wire wd_tick = osc_rise && (free_q == WD_TICK_LAST);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            free_q <= '0;
            ft_lvl_q <= 1'b0;
        end else begin
            free_q <= osc_rise ? free_q + 11'h001 : free_q;
            ft_lvl_q <= ft_edge ? !ft_lvl_q : ft_lvl_q;
        end
    end

    // ==========================================================
    // alarm compare
    wire [3:0] rpt = {alm_q[3][BIT_MSB], alm_q[2][BIT_MSB], alm_q[1][BIT_MSB],
        alm_q[0][BIT_MSB]};
    wire m_s = bcd_eq(alm_q[0], cur_time_i.sec);
    wire m_m = bcd_eq(alm_q[1], cur_time_i.min);
    wire m_h = bcd_eq(alm_q[2], cur_time_i.hour);
    wire m_d = bcd_eq(alm_q[3], cur_time_i.date);
    wire alm_off = (rpt == RPT_MONTH) && (alm_q[3][6:0] == DATE_OFF);
    wire alm_hit =
        (rpt == RPT_SEC) ? 1'b1 :
        (rpt == RPT_MIN) ? m_s :
        (rpt == RPT_HOUR) ? (m_s && m_m) :
        (rpt == RPT_DAY) ? (m_s && m_m && m_h) :
        (rpt == RPT_MONTH) ? (m_s && m_m && m_h && m_d) : 1'b1;
    wire alm_evt = tick_d2_q && alm_hit && !alm_off;

    // ==========================================================
    // watchdog
    wire watchdog_steering = wdog_q[BIT_MSB];
    wire wd_en = (wdog_q[6:2] != 5'h00);
    wire wd_exp = wd_en && wd_tick && (wd_cnt_q <= 11'h001) && !wr_wdog;
    wire wd_rst = wd_exp && watchdog_steering;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_cnt_q <= '0;
        end else if (wr_wdog) begin
            wd_cnt_q <= wd_units(wd);
        end else if (wd_exp) begin
            wd_cnt_q <= wd_units(wdog_q);
        end else if (wd_en && wd_tick) begin
            wd_cnt_q <= wd_cnt_q - 11'h001;
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdog_q <= REG_RESET;
        end else if (go_down || go_up || wd_rst) begin
            wdog_q <= REG_RESET;
        end else if (wr_wdog) begin
            wdog_q <= wd;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_q <= REG_RESET;
            ft_q <= 1'b0;
            st_q <= 1'b0;
        end else begin
            if (go_up || wd_rst) begin
                irq_en_q[IRQ_AFE] <= 1'b0;
                irq_en_q[IRQ_ABE] <= 1'b0;
            end else if (wr_irq) begin
                irq_en_q <= wd;
            end
            if (go_down || go_up || wd_rst) begin
                ft_q <= 1'b0;
            end else if (wr_day) begin
                ft_q <= wd[DAY_FT];
            end
            if (wr_sec) begin
                st_q <= wd[BIT_MSB];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= REG_RESET;
        end else if (go_up) begin
            ctrl_q[CTRL_WR] <= 1'b0;
            ctrl_q[CTRL_RD] <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q <= wd;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                alm_q[i] <= REG_RESET;
            end
        end else if (wr_alm) begin
            alm_q[alm_wi] <= wd;
        end
    end

    // ==========================================================
    // flags, set wins over read clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            af_q <= 1'b0;
            wdf_q <= 1'b0;
            wd_irq_q <= 1'b0;
            rd_flags_q <= 1'b0;
        end else begin
            rd_flags_q <= rd_flags;
            af_q <= alm_evt || (af_q && !clr_flags);
            wdf_q <= wd_exp || (wdf_q && !clr_flags);
            wd_irq_q <= (wd_exp && !watchdog_steering) || (wd_irq_q && !clr_flags);
        end
    end

    // ==========================================================
    // recovery timer and power state
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_q <= PWR_REC;
            rec_q <= REC_W'(REC_CYCLES - 1);
        end else begin
            pwr_q <= pwr_d;
            if (go_up || wd_rst) begin
                rec_q <= REC_W'(REC_CYCLES - 1);
            end else if (rec_q != '0) begin
                rec_q <= rec_q - REC_W'(1);
            end
        end
    end

    // ==========================================================
    // second tick and pin drivers
    wire afe = irq_en_q[IRQ_AFE];
    wire abe = irq_en_q[IRQ_ABE];
    wire irq_act = (af_q && afe && (!battery || abe)) || wd_irq_q;
    wire ft_on = !st_q && ft_q && !afe && (watchdog_steering || wdog_q == REG_RESET)
        && !irq_act && !battery;
    wire rst_act = (pwr_q != PWR_UP) || (rec_q != '0);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q <= 1'b0;
            tick_d1_q <= 1'b0;
            tick_d2_q <= 1'b0;
            irq_oe_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            tick_q <= sec_end;
            tick_d1_q <= tick_q;
            tick_d2_q <= tick_d1_q;
            irq_oe_q <= irq_act || (ft_on && ft_lvl_q);
            data_q <= rd_data;
        end
    end

    assign sec_tick_o = tick_q;
    assign data_o = data_q;
    assign data_oe_o = rd_act && rd_hit;
    assign interrupt_test_out_n_o = 1'b0;
    assign interrupt_test_oe_o = irq_oe_q;
    assign reset_out_n_o = 1'b0;
    assign reset_out_oe_o = rst_act;

endmodule
`default_nettype wire

//--- bench/rcaw_host_model.sv
// host model: byte writes and reads on the async memory pins
// assumes the bench clock; drives only on falling edges
`timescale 1ns/10ps
`default_nettype none
module rcaw_host_model import rcaw_pkg::*; (
    // clock
    input wire logic ref_clk_i,
    // memory pins
    output var rcaw_bus_type bus_o,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i
);
    initial bus_o = BUS_IDLE;
    // ==========================================================
    // write, data held past the rise of we_n
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        @(negedge ref_clk_i);
        bus_o = '{a, v, 1'b0, 1'b1, 1'b0};
        repeat (5) @(negedge ref_clk_i);
        bus_o.we_n = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        bus_o = '{a, ~v, 1'b1, 1'b1, 1'b1};
        repeat (5) @(negedge ref_clk_i);
    endtask
    // ==========================================================
    // read, ends in a deselect so the next read is fresh
    task automatic rd(input logic [12:0] a, output logic [7:0] v, output logic seen);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        bus_o = '{a, ~bus_o.data, 1'b0, 1'b0, 1'b1};
        while (data_oe_i !== 1'b1 && n < 8) begin
            @(negedge ref_clk_i);
            n++;
        end
        seen = data_oe_i;
        repeat (2) @(negedge ref_clk_i);
        v = data_i;
        bus_o = '{a, ~bus_o.data, 1'b1, 1'b1, 1'b1};
        repeat (5) @(negedge ref_clk_i);
    endtask
endmodule
`default_nettype wire

//--- bench/rcaw_core_props.sv
// checker on the supervisory block's pins
// assumes one clock domain and the async reset of the block
`timescale 1ns/10ps
`default_nettype none
module rcaw_core_props import rcaw_pkg::*; #(
    parameter int REC_CYCLES = REC_CYCLES_DEF
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // watched pins
    input wire rcaw_bus_type bus_i,
    input wire logic data_oe_o,
    input wire logic power_fail_i,
    input wire logic sec_tick_o,
    input wire logic interrupt_test_out_n_o,
    input wire logic reset_out_n_o,
    input wire logic reset_out_oe_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // length of the reset pin low time with supply good
    logic [31:0] low_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_q <= '0;
        end else if (!reset_out_oe_o || power_fail_i) begin
            low_q <= '0;
        end else begin
            low_q <= low_q + 32'h1;
        end
    end
    // ==========================================================
    // properties
    a_tick_one_cycle: assert property (sec_tick_o |=> !sec_tick_o)
        else $error("second tick longer than one cycle");
    a_irq_pin_low: assert property (interrupt_test_out_n_o == 1'b0)
        else $error("interrupt pin value not low");
    a_rst_pin_low: assert property (reset_out_n_o == 1'b0)
        else $error("reset pin value not low");
    a_fail_holds_reset: assert property (power_fail_i [*4] |=> reset_out_oe_o)
        else $error("reset pin released during supply fail");
    a_fail_refuses_bus: assert property (power_fail_i [*4] |=> !data_oe_o)
        else $error("bus answered during supply fail");
    a_read_needs_strobes: assert property ($rose(data_oe_o) |->
        $past(!bus_i.ce_n && !bus_i.oe_n && bus_i.we_n, 2))
        else $error("read data driven without read strobes");
    a_deselect_drops_oe: assert property (bus_i.ce_n [*4] |=> !data_oe_o)
        else $error("read data driven after deselect");
    a_reset_pulse_len: assert property ($fell(reset_out_oe_o) |->
        (low_q >= REC_CYCLES - 2) && (low_q <= REC_CYCLES + 6))
        else $error("reset low time off recovery time");
endmodule
bind rcaw_core rcaw_core_props #(.REC_CYCLES(REC_CYCLES)) u_props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus_i), .data_oe_o(data_oe_o),
    .power_fail_i(power_fail_i), .sec_tick_o(sec_tick_o),
    .interrupt_test_out_n_o(interrupt_test_out_n_o), .reset_out_n_o(reset_out_n_o),
    .reset_out_oe_o(reset_out_oe_o));
`default_nettype wire

//--- bench/test_rtc_calib_alarm_watchdog.sv
// bench: registers, watchdog, test output, supply fail
// assumes crystal stand-in of period 4 cycles and short recovery
`timescale 1ns/10ps
`default_nettype none
module test_rtc_calib_alarm_watchdog import rcaw_pkg::*;;
    localparam int REC = 50;
    localparam int UNIT = 8192;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic osc = 1'b0;
    logic pf = 1'b0;
    rcaw_bus_type bus;
    logic [7:0] data_o, d;
    logic data_oe, tick, irq_n, irq_oe, rst_n, rst_oe, s;
    int bad_count = 0;
    int compares = 0;
    int n;
    always #4 ref_clk_i = ~ref_clk_i;
    always begin
        repeat (2) @(negedge ref_clk_i);
        osc = ~osc;
    end
    rcaw_core #(.REC_CYCLES(REC)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .bus_i(bus), .data_o(data_o), .data_oe_o(data_oe), .osc_32k_i(osc),
        .power_fail_i(pf), .cur_time_i('0), .sec_tick_o(tick),
        .interrupt_test_out_n_o(irq_n), .interrupt_test_oe_o(irq_oe),
        .reset_out_n_o(rst_n), .reset_out_oe_o(rst_oe));
    rcaw_host_model host (.ref_clk_i(ref_clk_i), .bus_o(bus), .data_i(data_o),
        .data_oe_i(data_oe));
    // ==========================================================
    // helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_pin(input logic rp, input logic lvl, input int lim, output int k);
        k = 0;
        while ((rp ? rst_oe : irq_oe) !== lvl && k < lim) begin
            @(negedge ref_clk_i);
            k++;
        end
    endtask
    task automatic rises(input int cyc, output int r);
        logic p;
        r = 0;
        p = irq_oe;
        repeat (cyc) begin
            @(negedge ref_clk_i);
            if (irq_oe === 1'b1 && p !== 1'b1) r++;
            p = irq_oe;
        end
    endtask
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        repeat (16) @(negedge ref_clk_i);
        rst_i = 1'b0;
        chk("reset pin", rst_oe, 1);
        wait_pin(1, 0, REC + 20, n);
        chk("recovery", n >= REC - 1 && n <= REC + 6, 1);
        repeat (4) @(negedge ref_clk_i);
        host.wr(ADDR_CTRL, 8'h3F);
        host.rd(ADDR_CTRL, d, s);
        chk("ctrl max", d, 8'h3F);
        host.wr(ADDR_CTRL, 8'h0A);
        host.rd(ADDR_CTRL, d, s);
        chk("ctrl sign", d, 8'h0A);
        host.wr(ADDR_WDOG, 8'h7F);
        host.rd(ADDR_WDOG, d, s);
        chk("wdog", d, 8'h7F);
        host.rd(13'h1FF1, d, s);
        chk("unmapped", s, 0);
    endtask
    task automatic t_wd_irq();
        host.wr(ADDR_WDOG, 8'h04);
        wait_pin(0, 1, 3 * UNIT, n);
        chk("wd span", n <= 2 * UNIT, 1);
        chk("wd no reset", rst_oe, 0);
        host.wr(ADDR_WDOG, 8'h00);
        host.rd(ADDR_FLAGS, d, s);
        chk("wdf set", d, 8'h80);
        chk("irq off", irq_oe, 0);
        host.rd(ADDR_FLAGS, d, s);
        chk("wdf clear", d, 8'h00);
        host.wr(ADDR_WDOG, 8'h08);
        repeat (5) begin
            repeat (4000) @(negedge ref_clk_i);
            host.wr(ADDR_WDOG, 8'h08);
        end
        chk("wd restart", irq_oe, 0);
    endtask
    task automatic t_wd_rst();
        host.wr(ADDR_IRQ_EN, 8'hA0);
        host.wr(ADDR_DAY, 8'h40);
        host.wr(ADDR_WDOG, 8'h84);
        wait_pin(1, 1, 3 * UNIT, n);
        chk("steer span", n <= 2 * UNIT, 1);
        wait_pin(1, 0, REC + 20, n);
        chk("pulse", n >= REC - 1 && n <= REC + 6, 1);
        repeat (4) @(negedge ref_clk_i);
        host.rd(ADDR_WDOG, d, s);
        chk("wd cleared", d, 8'h00);
        host.rd(ADDR_IRQ_EN, d, s);
        chk("enables cleared", d, 8'h00);
        host.rd(ADDR_DAY, d, s);
        chk("test cleared", d, 8'h00);
        host.rd(ADDR_FLAGS, d, s);
        chk("wdf steer", d, 8'h80);
    endtask
    task automatic t_freq();
        host.wr(ADDR_WDOG, 8'h7C);
        host.wr(ADDR_DAY, 8'h40);
        rises(600, n);
        chk("test denied", n, 0);
        pf = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        chk("fail reset", rst_oe, 1);
        pf = 1'b0;
        wait_pin(1, 0, REC + 20, n);
        chk("pf recovery", n >= REC && n <= REC + 8, 1);
        repeat (4) @(negedge ref_clk_i);
        host.rd(ADDR_DAY, d, s);
        chk("test off", d, 8'h00);
        host.rd(ADDR_WDOG, d, s);
        chk("wd off", d, 8'h00);
        host.wr(ADDR_DAY, 8'h40);
        wait_pin(0, 0, 400, n);
        wait_pin(0, 1, 400, n);
        wait_pin(0, 0, 400, n);
        chk("half period", n >= 126 && n <= 130, 1);
        host.wr(ADDR_SEC, 8'h80);
        repeat (150) @(negedge ref_clk_i);
        rises(600, n);
        chk("halted", n, 0);
    endtask
    initial begin
        t_regs();
        t_wd_irq();
        t_wd_rst();
        t_freq();
        summarize();
    end
    initial begin
        repeat (95000) @(negedge ref_clk_i);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
